// File: lagg_pkg.sv
// Shared constants and types for the aggregator state and statistics block.
package lagg_pkg;
	// Register byte offsets on the Wishbone slave.
	localparam logic [7:0] ADR_ADMIN = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_LAST = 8'h08;
	localparam logic [7:0] ADR_TIME = 8'h0c;
	localparam logic [7:0] ADR_RATE_LO = 8'h10;
	localparam logic [7:0] ADR_RATE_HI = 8'h14;
	localparam logic [1:0] ADR_CNT_PAGE = 2'h1;
	// Counter indices; counter i sits at byte 8'h40 + 4*i.
	localparam int NCNT = 10;
	localparam int CIW = 4;
	localparam logic [3:0] CNT_TX_OCT = 4'h0;
	localparam logic [3:0] CNT_RX_OCT = 4'h1;
	localparam logic [3:0] CNT_TX_FRM = 4'h2;
	localparam logic [3:0] CNT_RX_FRM = 4'h3;
	localparam logic [3:0] CNT_TX_GRP = 4'h4;
	localparam logic [3:0] CNT_RX_GRP = 4'h5;
	localparam logic [3:0] CNT_TX_BC = 4'h6;
	localparam logic [3:0] CNT_RX_BC = 4'h7;
	localparam logic [3:0] CNT_TX_DROP = 4'h8;
	localparam logic [3:0] CNT_RX_DROP = 4'h9;
	localparam logic [3:0] CNT_LAST = 4'h9;
	// Values after reset.
	localparam logic ADMIN_RST = 1'b1;
	// Time since reset advances in hundredths of a second.
	localparam int CLK_NS = 40;
	localparam int TICK_NS = 10000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	typedef enum logic [3:0] {
		S_INIT = 4'h1,
		S_IDLE = 4'h2,
		S_UPD = 4'h4,
		S_BRD = 4'h8
	} lagg_seq_t;
endpackage : lagg_pkg

// File: lagg_mem_if.sv
// Port bundle between the sequencer and the counter memory.
`timescale 1ns/1ns
interface lagg_mem_if #(
	parameter int DW = 32,
	parameter int AW = 4
);
	logic rd_en;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	modport user (output rd_en, rd_addr, wr_en, wr_addr, wr_data,
		input rd_data);
	modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data,
		output rd_data);
endinterface : lagg_mem_if

// File: lagg_cnt_mem.sv
// Statistics counter storage with registered read data.
`timescale 1ns/1ns
module lagg_cnt_mem #(
	parameter int DW = 32,
	parameter int DEPTH = 10,
	parameter int AW = 4
) (
	input wire logic clk_i,
	lagg_mem_if.mem m
);
	import lagg_pkg::*;
	logic [DW-1:0] ram [0:DEPTH-1];

	always_ff @(posedge clk_i)
	begin
		if (m.wr_en)
			ram[m.wr_addr] <= m.wr_data;
		if (m.rd_en)
			m.rd_data <= ram[m.rd_addr];
	end
endmodule : lagg_cnt_mem

// File: lagg_timebase.sv
// Free running time since reset, in ticks of a clock divider.
`timescale 1ns/1ns
module lagg_timebase #(
	parameter int TICK_CYC = lagg_pkg::TICK_CYC,
	parameter int TW = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic [TW-1:0] time_o
);
	import lagg_pkg::*;
	localparam int DW = $clog2(TICK_CYC + 1);
	logic [DW-1:0] div_r;
	wire tick = div_r == DW'(TICK_CYC - 1);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_r <= '0;
			time_o <= '0;
		end
		else
		begin
			div_r <= tick ? '0 : div_r + DW'(1);
			if (tick)
				time_o <= time_o + TW'(1);
		end
	end
endmodule : lagg_timebase

// File: lagg_state_stats.sv
// Aggregator state control and statistics counters behind Wishbone.
`timescale 1ns/1ns
// How it works
// - Admin down forces the operational state down.
// - Operational up needs admin up and an attached collecting port.
// - No attached collecting port, or none attached, gives down.
// - Admin register reads back its value; writes with byte lane 0 enabled replace it.
// - Each operational change latches time since reset, read only.
// - State older than the last management reinit reads time zero.
// - Aggregate rate is active link count times one link's rate.
// - Counters are read only, cleared only by reset; octets keep up.
// - Frame and drop counters keep up with the frame rate.
// - Tx octets add data frame lengths, control frames excluded.
// - Rx octets add collected data lengths, not control or drops.
// - Tx frames count data frames, control excluded, drops excluded.
// - Rx frames count collected data frames only.
// - Tx group counts non-broadcast group data frames.
// - Rx group counts collected non-broadcast group data frames.
// - Tx broadcast counts broadcast data frames.
// - Rx broadcast skips control, bad slow frames, collection drops.
// - Tx drops count flush discards and excess collision discards.
// - Rx drops count data frames on ports not collecting.
module lagg_state_stats #(
	parameter int PORTS = 4,
	parameter int PIW = 2,
	parameter int CW = 32,
	parameter int TICK_CYC = lagg_pkg::TICK_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [PORTS-1:0] port_attached_i,
	input wire logic [PORTS-1:0] port_collecting_i,
	input wire logic [PORTS-1:0] port_distributing_i,
	input wire logic [31:0] link_bps_i,
	input wire logic mgmt_reinit_i,
	input wire logic tx_frame_i,
	input wire logic [PIW-1:0] tx_port_i,
	input wire logic [15:0] tx_len_i,
	input wire logic tx_ctrl_pdu_i,
	input wire logic tx_group_i,
	input wire logic tx_bcast_i,
	input wire logic tx_flush_drop_i,
	input wire logic tx_coll_drop_i,
	input wire logic rx_frame_i,
	input wire logic [PIW-1:0] rx_port_i,
	input wire logic [15:0] rx_len_i,
	input wire logic rx_ctrl_pdu_i,
	input wire logic rx_bad_slow_i,
	input wire logic rx_group_i,
	input wire logic rx_bcast_i,
	output logic agg_admin_state_o,
	output logic agg_oper_state_o
);
	import lagg_pkg::*;

	function automatic logic [CIW-1:0] first_set(
		input logic [NCNT-1:0] v
	);
		first_set = '0;
		for (int i = NCNT - 1; i >= 0; i--)
			if (v[i])
				first_set = CIW'(i);
	endfunction : first_set

	function automatic logic [7:0] pop_count(input logic [PORTS-1:0] v);
		pop_count = '0;
		for (int i = 0; i < PORTS; i++)
			pop_count = pop_count + 8'(v[i]);
	endfunction : pop_count

	logic agg_admin_state_r;
	logic agg_oper_state_r;
	logic stale_r;
	logic [31:0] last_state_change_time_r;
	logic [31:0] time_since_reset;
	logic [63:0] aggregate_bit_rate_r;
	lagg_seq_t st_r;
	lagg_seq_t st_nxt;
	logic [NCNT-1:0] pend_r;
	logic [NCNT-1:0] pend_set;
	logic [NCNT-1:0] pend_nxt;
	logic [CW-1:0] tx_oct_r;
	logic [CW-1:0] rx_oct_r;
	logic [CW-1:0] tx_oct_nxt;
	logic [CW-1:0] rx_oct_nxt;
	logic [CW-1:0] evt_r [NCNT];
	logic [CIW-1:0] sidx_r;
	logic [CIW-1:0] init_r;
	logic ack_r;
	logic [31:0] dat_r;

	lagg_mem_if #(.DW(CW), .AW(CIW)) m ();

	lagg_cnt_mem #(
		.DW(CW),
		.DEPTH(NCNT),
		.AW(CIW)
	) u_mem (
		.clk_i(clk_i),
		.m(m)
	);

	lagg_timebase #(
		.TICK_CYC(TICK_CYC),
		.TW(32)
	) u_time (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.time_o(time_since_reset)
	);

	// Operational state and the time it was entered.
	wire any_coll = |(port_attached_i & port_collecting_i);
	wire oper_nxt = agg_admin_state_r & any_coll;
	wire oper_chg = oper_nxt != agg_oper_state_r;
	wire [31:0] last_rd = stale_r ? 32'h0 : last_state_change_time_r;
	wire [7:0] active_w = pop_count(port_attached_i & port_collecting_i
		& port_distributing_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			agg_oper_state_r <= 1'b0;
			last_state_change_time_r <= 32'h0;
			stale_r <= 1'b0;
			aggregate_bit_rate_r <= 64'h0;
		end
		else
		begin
			agg_oper_state_r <= oper_nxt;
			if (oper_chg)
				last_state_change_time_r <= time_since_reset;
			// A change in the same cycle as a reinit is newer than it.
			stale_r <= !oper_chg && (stale_r || mgmt_reinit_i);
			aggregate_bit_rate_r <= 64'(active_w) * 64'(link_bps_i);
		end
	end

	// Frame events; a port counts only while attached here, flush discards excepted.
	wire tx_mem = port_attached_i[tx_port_i];
	wire rx_mem = port_attached_i[rx_port_i];
	wire tx_ok = tx_frame_i && tx_mem && !tx_ctrl_pdu_i;
	wire rx_data = rx_frame_i && rx_mem && !rx_ctrl_pdu_i && !rx_bad_slow_i;
	wire rx_ok = rx_data && port_collecting_i[rx_port_i];
	wire rx_drop = rx_data && !port_collecting_i[rx_port_i];
	wire tx_drop = tx_flush_drop_i || (tx_coll_drop_i && tx_mem);

	assign pend_set[CNT_TX_OCT] = tx_ok;
	assign pend_set[CNT_RX_OCT] = rx_ok;
	assign pend_set[CNT_TX_FRM] = tx_ok;
	assign pend_set[CNT_RX_FRM] = rx_ok;
	assign pend_set[CNT_TX_GRP] = tx_ok && tx_group_i && !tx_bcast_i;
	assign pend_set[CNT_RX_GRP] = rx_ok && rx_group_i && !rx_bcast_i;
	assign pend_set[CNT_TX_BC] = tx_ok && tx_bcast_i;
	assign pend_set[CNT_RX_BC] = rx_ok && rx_bcast_i;
	assign pend_set[CNT_TX_DROP] = tx_drop;
	assign pend_set[CNT_RX_DROP] = rx_drop;

	// Wishbone decode.
	wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	wire adr_cnt = (wb_adr_i[7:6] == ADR_CNT_PAGE)
		&& (wb_adr_i[5:2] <= CNT_LAST);
	wire cnt_rd = bus_req && adr_cnt && !wb_we_i;
	wire reg_acc = bus_req && !cnt_rd;
	wire admin_wr = reg_acc && wb_we_i && (wb_adr_i == ADR_ADMIN)
		&& wb_sel_i[0];
	wire [31:0] reg_rd =
		(wb_adr_i == ADR_ADMIN) ? {31'h0, agg_admin_state_r} :
		(wb_adr_i == ADR_STATUS) ? {31'h0, agg_oper_state_r} :
		(wb_adr_i == ADR_LAST) ? last_rd :
		(wb_adr_i == ADR_TIME) ? time_since_reset :
		(wb_adr_i == ADR_RATE_LO) ? aggregate_bit_rate_r[31:0] :
		(wb_adr_i == ADR_RATE_HI) ? aggregate_bit_rate_r[63:32] :
		32'h0;

	// Counter update sequencer. One read-modify-write per counter takes
	// two cycles; pending bits and per-counter sums absorb events that
	// arrive meanwhile, so no count is lost however close they come.
	wire in_init = st_r == S_INIT;
	wire in_upd = st_r == S_UPD;
	wire [CW-1:0] inc_w = (sidx_r == CNT_TX_OCT) ? tx_oct_r :
		(sidx_r == CNT_RX_OCT) ? rx_oct_r : evt_r[sidx_r];
	wire [NCNT-1:0] pend_clr = in_upd ? (NCNT'(1) << sidx_r) : '0;

	assign m.rd_en = st_r == S_IDLE;
	assign m.rd_addr = cnt_rd ? wb_adr_i[5:2] : first_set(pend_r);
	assign m.wr_en = in_upd || in_init;
	assign m.wr_addr = in_init ? init_r : sidx_r;
	assign m.wr_data = in_init ? '0 : m.rd_data + inc_w;
	// A set in the cycle of its clear survives.
	assign pend_nxt = (pend_r & ~pend_clr) | pend_set;
	assign tx_oct_nxt = (pend_clr[CNT_TX_OCT] ? '0 : tx_oct_r)
		+ (tx_ok ? CW'(tx_len_i) : '0);
	assign rx_oct_nxt = (pend_clr[CNT_RX_OCT] ? '0 : rx_oct_r)
		+ (rx_ok ? CW'(rx_len_i) : '0);

	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			S_INIT:
				if (init_r == CNT_LAST)
					st_nxt = S_IDLE;
			S_IDLE:
				if (cnt_rd)
					st_nxt = S_BRD;
				else if (|pend_r)
					st_nxt = S_UPD;
			S_UPD:
				st_nxt = S_IDLE;
			S_BRD:
				st_nxt = S_IDLE;
			default:
				st_nxt = S_INIT;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r <= S_INIT;
			init_r <= '0;
			sidx_r <= '0;
			pend_r <= '0;
			tx_oct_r <= '0;
			rx_oct_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			if (in_init)
				init_r <= init_r + CIW'(1);
			if (m.rd_en)
				sidx_r <= m.rd_addr;
			pend_r <= pend_nxt;
			tx_oct_r <= tx_oct_nxt;
			rx_oct_r <= rx_oct_nxt;
		end
	end

	// Event counts gather here until their counter's turn comes, so
	// back-to-back frames on one counter are never folded into one.
	always_ff @(posedge clk_i)
	begin
		for (int i = 0; i < NCNT; i++)
			if (rst_i)
				evt_r[i] <= '0;
			else
				evt_r[i] <= (pend_clr[i] ? '0 : evt_r[i])
					+ CW'(pend_set[i]);
	end

	// Bus answer; counter writes are acknowledged and ignored.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			agg_admin_state_r <= ADMIN_RST;
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end
		else
		begin
			if (admin_wr)
				agg_admin_state_r <= wb_dat_i[0];
			ack_r <= reg_acc || (st_r == S_BRD);
			if (st_r == S_BRD)
				dat_r <= m.rd_data;
			else if (reg_acc)
				dat_r <= reg_rd;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign agg_admin_state_o = agg_admin_state_r;
	assign agg_oper_state_o = agg_oper_state_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_ADMIN_DOWN: assert property (
		!agg_admin_state_r |=> !agg_oper_state_r)
		else $error("oper up while admin down");
	AST_OPER_UP: assert property (
		$rose(agg_oper_state_r) |-> $past(agg_admin_state_r) && $past(any_coll))
		else $error("oper up without cause");
	AST_OPER_DOWN: assert property (
		!any_coll |=> !agg_oper_state_r)
		else $error("oper up with no collecting port");
	AST_ADMIN_WR: assert property (
		admin_wr |=> wb_ack_o && agg_admin_state_r == $past(wb_dat_i[0]))
		else $error("admin write lost");
	AST_STAMP: assert property (
		(agg_oper_state_r != $past(agg_oper_state_r))
		|-> last_rd == $past(time_since_reset))
		else $error("change time not latched");
	AST_STALE: assert property (
		mgmt_reinit_i && !oper_chg |=> stale_r && last_rd == 32'h0)
		else $error("stale change time not zero");
	AST_RATE: assert property (
		##1 aggregate_bit_rate_r
		== 64'($past(active_w)) * 64'($past(link_bps_i)))
		else $error("aggregate rate wrong");
	AST_TX_PEND: assert property (
		tx_ok |=> pend_r[CNT_TX_FRM] && pend_r[CNT_TX_OCT])
		else $error("tx frame not queued");
	AST_RX_DROP: assert property (
		rx_drop |-> !pend_set[CNT_RX_FRM] ##1 pend_r[CNT_RX_DROP])
		else $error("rx drop not queued");
	AST_WRAP: assert property (
		in_upd && m.rd_data == '1 && inc_w == CW'(1) |-> m.wr_data == '0)
		else $error("counter does not wrap");
	AST_ACK_PULSE: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_RX_OK: assert property (
		rx_ok |=> pend_r[CNT_RX_FRM] && pend_r[CNT_RX_OCT])
		else $error("rx frame not queued");
	AST_TX_CTRL: assert property (
		tx_frame_i && tx_ctrl_pdu_i |-> !pend_set[CNT_TX_OCT] && !tx_ok)
		else $error("tx control frame counted");
	AST_TX_BC: assert property (
		tx_ok && tx_bcast_i |-> pend_set[CNT_TX_BC] && !pend_set[CNT_TX_GRP])
		else $error("tx broadcast miscounted");
	AST_RX_GRP: assert property (
		rx_ok && rx_group_i && !rx_bcast_i |=> pend_r[CNT_RX_GRP])
		else $error("rx group frame not queued");
	AST_RX_SLOW: assert property (
		rx_bad_slow_i |-> !pend_set[CNT_RX_BC] && !pend_set[CNT_RX_OCT])
		else $error("bad slow frame counted");
	AST_TX_FLUSH: assert property (
		tx_flush_drop_i |=> pend_r[CNT_TX_DROP])
		else $error("flush discard not queued");
	AST_EVT_SUM: assert property (
		pend_set[CNT_TX_FRM] && !pend_clr[CNT_TX_FRM]
		|=> evt_r[CNT_TX_FRM] == $past(evt_r[CNT_TX_FRM]) + CW'(1))
		else $error("tx frame event lost");
endmodule : lagg_state_stats

// File: lagg_port_model.sv
// Behavioural model of the member ports and the management agent.
`timescale 1ns/1ns
module lagg_port_model #(
	parameter int PORTS = 4,
	parameter int PIW = 2,
	parameter logic [31:0] LINK_BPS = 32'h0000_03e8
) (
	input wire logic clk_i,
	output logic [PORTS-1:0] att_o,
	output logic [PORTS-1:0] col_o,
	output logic [PORTS-1:0] dis_o,
	output logic [31:0] bps_o,
	output logic reinit_o,
	output logic [1:0] drop_o,
	output logic tx_frame_o,
	output logic rx_frame_o,
	output logic [PIW-1:0] tx_port_o,
	output logic [PIW-1:0] rx_port_o,
	output logic [15:0] tx_len_o,
	output logic [15:0] rx_len_o,
	output logic [3:0] tx_kind_o,
	output logic [3:0] rx_kind_o
);
	assign bps_o = LINK_BPS;
	initial
	begin
		{att_o, col_o, dis_o, reinit_o, drop_o} = '0;
		{tx_frame_o, rx_frame_o, tx_port_o, rx_port_o} = '0;
		{tx_len_o, rx_len_o, tx_kind_o, rx_kind_o} = '0;
	end
	task automatic ports(input logic [PORTS-1:0] a, c, d);
		@(posedge clk_i);
		att_o <= a;
		col_o <= c;
		dis_o <= d;
	endtask : ports
	// Kind bits are control PDU, bad slow frame, group and broadcast.
	task automatic frame(input logic tx, input logic [PIW-1:0] p,
		input logic [15:0] n, input logic [3:0] k);
		@(posedge clk_i);
		tx_frame_o <= tx;
		rx_frame_o <= !tx;
		tx_port_o <= p;
		rx_port_o <= p;
		tx_len_o <= n;
		rx_len_o <= n;
		tx_kind_o <= k;
		rx_kind_o <= k;
	endtask : frame
	// Bits are reinit, flush discard and collision discard.
	task automatic pulse(input logic [2:0] m, input logic [PIW-1:0] p);
		@(posedge clk_i);
		{reinit_o, drop_o} <= m;
		tx_port_o <= p;
	endtask : pulse
	// Qualifiers are scrambled between events so a stale value never helps.
	task automatic idle;
		@(posedge clk_i);
		{tx_frame_o, rx_frame_o, reinit_o, drop_o} <= '0;
		tx_len_o <= ~tx_len_o;
		rx_len_o <= ~rx_len_o;
		tx_kind_o <= ~tx_kind_o;
		rx_kind_o <= ~rx_kind_o;
	endtask : idle
endmodule : lagg_port_model

// File: tb_top.sv
// Self-checking bench for the aggregator state and statistics block.
`timescale 1ns/1ns
module tb_top;
	import lagg_pkg::*;
	typedef struct packed {
		logic [3:0] a;
		logic [3:0] c;
		logic [3:0] d;
		logic adm;
		logic op;
		logic [31:0] rate;
	} lagg_row_t;
	localparam lagg_row_t ROWS [8] = '{
		'{4'h0, 4'h0, 4'h0, 1'b1, 1'b0, 32'h0},
		'{4'hf, 4'h0, 4'hf, 1'b1, 1'b0, 32'h0},
		'{4'h8, 4'h7, 4'hf, 1'b1, 1'b0, 32'h0},
		'{4'h1, 4'h1, 4'h0, 1'b1, 1'b1, 32'h0},
		'{4'h3, 4'h3, 4'h3, 1'b1, 1'b1, 32'h7d0},
		'{4'hf, 4'hf, 4'h0, 1'b0, 1'b0, 32'h0},
		'{4'h2, 4'h6, 4'h6, 1'b1, 1'b1, 32'h3e8},
		'{4'hf, 4'hf, 4'hf, 1'b1, 1'b1, 32'hfa0}};
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, tx_kind, rx_kind;
	logic [31:0] wb_dat_i, wb_dat_o, q, t0, lc, link_bps_i;
	logic agg_admin_state_o, agg_oper_state_o, mgmt_reinit_i;
	logic [3:0] port_attached_i, port_collecting_i, port_distributing_i;
	logic tx_frame_i, tx_ctrl_pdu_i, tx_group_i, tx_bcast_i;
	logic rx_frame_i, rx_ctrl_pdu_i, rx_bad_slow_i, rx_group_i, rx_bcast_i;
	logic tx_flush_drop_i, tx_coll_drop_i;
	logic [1:0] tx_port_i, rx_port_i, drops;
	logic [15:0] tx_len_i, rx_len_i;
	logic [31:0] exp_cnt [NCNT];
	int num_errors = 0;
	int n_checks = 0;
	assign {tx_ctrl_pdu_i, tx_group_i, tx_bcast_i} = {tx_kind[3], tx_kind[1:0]};
	assign {rx_ctrl_pdu_i, rx_bad_slow_i, rx_group_i, rx_bcast_i} = rx_kind;
	assign {tx_flush_drop_i, tx_coll_drop_i} = drops;
	lagg_state_stats #(.TICK_CYC(4)) i_lagg_state_stats (.*);
	lagg_port_model i_lagg_port_model (.clk_i(clk_i), .att_o(port_attached_i),
		.col_o(port_collecting_i), .dis_o(port_distributing_i),
		.bps_o(link_bps_i), .reinit_o(mgmt_reinit_i), .drop_o(drops),
		.tx_frame_o(tx_frame_i), .rx_frame_o(rx_frame_i), .tx_port_o(tx_port_i),
		.rx_port_o(rx_port_i), .tx_len_o(tx_len_i), .rx_len_o(rx_len_i),
		.tx_kind_o(tx_kind), .rx_kind_o(rx_kind));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Waits for ack without assuming a latency; counter reads take longer.
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (wb_ack_o !== 1'b1 && k < 50);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k >= 50)
		begin
			chk(32'h0, 32'h1);
			give_verdict;
		end
	endtask : wb
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rc
	task automatic rb(input logic [7:0] a, input logic e);
		wb(1'b0, a, 32'h0, q);
		chk({31'h0, q[0]}, {31'h0, e});
	endtask : rb
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial
	begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		{wb_adr_i, wb_sel_i, wb_dat_i} = {8'h0, 4'hf, 32'h0};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rb(ADR_ADMIN, ADMIN_RST);
		for (int i = 0; i < NCNT; i++)
			rc(8'h40 + 8'(4 * i), 32'h0);
		rc(8'h30, 32'h0);
		$display("test reset done");
		foreach (ROWS[i])
		begin
			wb(1'b1, ADR_ADMIN, {31'h0, ROWS[i].adm}, q);
			i_lagg_port_model.ports(ROWS[i].a, ROWS[i].c, ROWS[i].d);
			repeat (4) @(posedge clk_i);
			chk({31'h0, agg_oper_state_o}, {31'h0, ROWS[i].op});
			rb(ADR_STATUS, ROWS[i].op);
			rb(ADR_ADMIN, ROWS[i].adm);
			rc(ADR_RATE_LO, ROWS[i].rate);
			rc(ADR_RATE_HI, 32'h0);
		end
		$display("test state table done");
		wb_sel_i <= 4'he;
		wb(1'b1, ADR_ADMIN, 32'h0, q);
		wb_sel_i <= 4'hf;
		rb(ADR_ADMIN, 1'b1);
		chk({31'h0, agg_admin_state_o}, 32'h1);
		$display("test byte enable done");
		i_lagg_port_model.ports(4'h3, 4'h1, 4'h1);
		i_lagg_port_model.frame(1'b1, 2'd0, 16'd100, 4'h0);
		i_lagg_port_model.frame(1'b1, 2'd1, 16'd60, 4'h2);
		i_lagg_port_model.frame(1'b1, 2'd0, 16'd70, 4'h3);
		i_lagg_port_model.frame(1'b1, 2'd0, 16'd128, 4'h8);
		i_lagg_port_model.frame(1'b1, 2'd2, 16'd50, 4'h0);
		i_lagg_port_model.frame(1'b0, 2'd0, 16'd80, 4'h0);
		i_lagg_port_model.frame(1'b0, 2'd0, 16'd64, 4'h2);
		i_lagg_port_model.frame(1'b0, 2'd0, 16'd64, 4'h3);
		i_lagg_port_model.frame(1'b0, 2'd0, 16'd90, 4'h8);
		i_lagg_port_model.frame(1'b0, 2'd0, 16'd77, 4'h5);
		i_lagg_port_model.frame(1'b0, 2'd1, 16'd40, 4'h0);
		i_lagg_port_model.idle();
		repeat (40) @(posedge clk_i);
		exp_cnt = '{32'd230, 32'd208, 3, 3, 1, 1, 1, 1, 0, 1};
		for (int i = 0; i < 5; i++)
			rc(8'h40 + 8'(4 * i), exp_cnt[i]);
		for (int i = 5; i < NCNT; i++)
			rc(8'h40 + 8'(4 * i), exp_cnt[i]);
		i_lagg_port_model.pulse(3'b010, 2'd0);
		i_lagg_port_model.pulse(3'b001, 2'd0);
		i_lagg_port_model.pulse(3'b001, 2'd2);
		i_lagg_port_model.idle();
		repeat (40) @(posedge clk_i);
		rc(8'h60, 32'h2);
		wb(1'b1, 8'h40, 32'hffff_ffff, q);
		rc(8'h40, 32'd230);
		$display("test counters done");
		wb(1'b0, ADR_TIME, 32'h0, t0);
		i_lagg_port_model.ports(4'h0, 4'h0, 4'h0);
		repeat (4) @(posedge clk_i);
		wb(1'b0, ADR_LAST, 32'h0, lc);
		wb(1'b0, ADR_TIME, 32'h0, q);
		chk({31'h0, lc >= t0 && lc <= q}, 32'h1);
		wb(1'b1, ADR_LAST, 32'h0, q);
		rc(ADR_LAST, lc);
		i_lagg_port_model.pulse(3'b100, 2'd0);
		i_lagg_port_model.idle();
		repeat (4) @(posedge clk_i);
		rc(ADR_LAST, 32'h0);
		i_lagg_port_model.ports(4'h1, 4'h1, 4'h0);
		repeat (4) @(posedge clk_i);
		wb(1'b0, ADR_LAST, 32'h0, q);
		chk({31'h0, q > lc}, 32'h1);
		$display("test timestamp done");
		wb(1'b1, ADR_ADMIN, 32'h0, q);
		rb(ADR_ADMIN, 1'b0);
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(8'h40, 32'h0);
		chk({31'h0, agg_admin_state_o}, {31'h0, ADMIN_RST});
		$display("test second reset done");
		give_verdict;
	end
endmodule : tb_top
